// ---- tbo_ctrl.v ----
// 10base-t operations and extended control two register bank, avalon-mm slave.
// assumes receive-path events arrive as one-cycle pulses or levels on clk.
`include "tbo_regs.vh"

module tbo_ctrl #(
  parameter LED_N   = 5,
  parameter HB_CYC  = (`TBO_HB_NS + `TBO_CLK_NS - 1) / `TBO_CLK_NS,
  parameter JAB_CYC = 4000
) (
  // clock and reset
  input  wire               clk,
  input  wire               rst_b,
  // avalon-mm slave
  input  wire [`TBO_ADDR_W-1:0] avs_address,
  input  wire               avs_read,
  input  wire               avs_write,
  input  wire [31:0]        avs_writedata,
  input  wire [3:0]         avs_byteenable,
  output reg  [31:0]        avs_readdata,
  output wire               avs_waitrequest,
  output reg  [1:0]         avs_response,
  // straps
  input  wire               node_repeater_strap,
  input  wire               config_priority_strap,
  input  wire [LED_N-1:0]   led_strap,
  // receive path
  input  wire               rx_jabber_seen,
  input  wire               rx_pol_reversed,
  input  wire               rx_valid_data,
  input  wire               rx_idle,
  input  wire               rx_link_pulse_ok,
  input  wire               partner_remote_fault,
  // transmit path and mode
  input  wire               tx_en,
  input  wire               rx_active,
  input  wire               full_duplex,
  input  wire               mode_10m,
  input  wire               pair_tx_positive_in,
  input  wire               pair_tx_negative_in,
  input  wire [LED_N-1:0]   led_status,
  // outputs
  output wire               pair_tx_positive,
  output wire               pair_tx_negative,
  output wire               pair_tx_oe,
  output wire               polarity_correct_en,
  output wire               jabber_check_en,
  output reg                tx_jabber_ff,
  output reg                col_heartbeat_ff,
  output wire               crs,
  output reg                link_pass_ff,
  output wire               tx100_power_down,
  output wire [LED_N-1:0]   led_out,
  output wire [LED_N-1:0]   led_oe
);

  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  reg rst_s1_ff;
  reg rst_s2_ff;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end
  wire rst_n = rst_s2_ff;

  // ------------------------------------------------------------
  // strap capture after reset release
  // ------------------------------------------------------------
  reg [3:0]       strap_cnt_ff;
  reg             strap_done_ff;
  reg [LED_N-1:0] led_pol_ff;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_cnt_ff  <= 4'h0;
      strap_done_ff <= 1'b0;
      led_pol_ff    <= {LED_N{1'b0}};
    end else if (!strap_done_ff) begin
      strap_cnt_ff <= strap_cnt_ff + 4'h1;
      if (strap_cnt_ff == `TBO_STRAP_CYC) begin
        strap_done_ff <= 1'b1;
        led_pol_ff    <= led_strap;
      end
    end
  end

  // ------------------------------------------------------------
  // register bank storage
  // ------------------------------------------------------------
  reg  [15:0] ops_ff;
  reg  [15:0] ext_ff;
  reg         rjab_ff;
  reg         polrev_ff;
  reg         rflt_ff;
  reg         rd_vld_ff;
  reg  [15:0] rd_word;
  reg         rd_hit;

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  wire [5:0]  idx      = avs_address[`TBO_ADDR_W-1:2];
  wire        hit_ops  = (idx == `TBO_IDX_OPS);
  wire        hit_ext  = (idx == `TBO_IDX_EXT2);
  wire        hit_stat = (idx == `TBO_IDX_STAT);
  wire [15:0] be_mask  = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  // ------------------------------------------------------------
  // read wait state
  // ------------------------------------------------------------
  // one stall cycle per read: the word is registered on the
  // first edge and stands when waitrequest is seen low
  wire        rd_first = avs_read & ~rd_vld_ff;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_vld_ff <= 1'b0;
    end else begin
      rd_vld_ff <= rd_first;
    end
  end

  assign avs_waitrequest = rd_first;

  // ------------------------------------------------------------
  // write path
  // ------------------------------------------------------------
  wire        wr_ops   = avs_write && hit_ops;
  wire        wr_ext   = avs_write && hit_ext;
  // clear-on-read only once per read, on the capturing edge
  wire        rd_ops   = rd_first && hit_ops && avs_byteenable[1];

  wire [15:0] ops_mask = `TBO_OPS_WMASK & be_mask;
  wire [15:0] ext_mask = `TBO_EXT_WMASK & be_mask;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ops_ff <= `TBO_OPS_RST;
    end else if (wr_ops) begin
      ops_ff <= (ops_ff & ~ops_mask) | (avs_writedata[15:0] & ops_mask);
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_ff <= `TBO_EXT_RST;
    end else if (wr_ext) begin
      ext_ff <= (ext_ff & ~ext_mask) | (avs_writedata[15:0] & ext_mask);
    end
  end

  // ------------------------------------------------------------
  // latched and live status
  // ------------------------------------------------------------
  // latched remote jabber: set wins over clear-on-read
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rjab_ff <= 1'b0;
    end else if (rx_jabber_seen) begin
      rjab_ff <= 1'b1;
    end else if (rd_ops) begin
      rjab_ff <= 1'b0;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      polrev_ff <= 1'b0;
    end else begin
      polrev_ff <= rx_pol_reversed;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rflt_ff <= 1'b0;
    end else begin
      rflt_ff <= partner_remote_fault;
    end
  end

  // ------------------------------------------------------------
  // mode derived enables
  // ------------------------------------------------------------
  wire        repeater = node_repeater_strap;
  // suppression never touches the stored inhibit bit
  wire        hb_en    = ~ops_ff[`TBO_OPS_HBINH] & ~full_duplex & ~repeater;

  // ------------------------------------------------------------
  // read words
  // ------------------------------------------------------------
  wire [15:0] ops_rd  = {rjab_ff, polrev_ff, ops_ff[13:0]};
  wire [15:0] ext_rd  = {node_repeater_strap, config_priority_strap, rflt_ff, ext_ff[12:0]};
  wire [15:0] stat_rd = {12'h000, hb_en, tx100_power_down, tx_jabber_ff, link_pass_ff};

  always @* begin
    rd_word = 16'h0000;
    rd_hit  = 1'b1;
    case (idx)
      `TBO_IDX_OPS: begin
        rd_word = ops_rd;
      end
      `TBO_IDX_EXT2: begin
        rd_word = ext_rd;
      end
      `TBO_IDX_STAT: begin
        rd_word = stat_rd;
      end
      default: begin
        rd_word = 16'h0000;
        rd_hit  = 1'b0;
      end
    endcase
  end

  // ------------------------------------------------------------
  // bus answer registers
  // ------------------------------------------------------------
  // unmapped indices answer with a slave error and a zero word
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
      avs_response <= 2'h0;
    end else if (rd_first || avs_write) begin
      avs_response <= rd_hit ? 2'h0 : 2'h2;
      avs_readdata <= {16'h0000, rd_word};
    end
  end

  // ------------------------------------------------------------
  // receive pair and transmit jabber controls
  // ------------------------------------------------------------
  // remote jabber feeds nothing here, flag only
  assign polarity_correct_en = ~ops_ff[`TBO_OPS_APINH];
  assign jabber_check_en     = ~ops_ff[`TBO_OPS_JABINH];

  // ------------------------------------------------------------
  // transmit pair
  // ------------------------------------------------------------
  // floated pair shows low data; oe is the real high-z control
  assign pair_tx_oe          = ~ext_ff[`TBO_EXT_TXZ];
  assign pair_tx_positive    = pair_tx_positive_in & pair_tx_oe;
  assign pair_tx_negative    = pair_tx_negative_in & pair_tx_oe;

  // ------------------------------------------------------------
  // power down and carrier sense
  // ------------------------------------------------------------
  assign tx100_power_down    = ext_ff[`TBO_EXT_APD] & mode_10m;
  assign crs = repeater ? rx_active : (rx_active | tx_en);

  // ------------------------------------------------------------
  // leds
  // ------------------------------------------------------------
  // active level is the inverse of the sampled strap; dark until sampled
  genvar gi;
  generate
    for (gi = 0; gi < LED_N; gi = gi + 1) begin : g_led
      wire on;
      assign on          = ext_ff[`TBO_EXT_FLED] | led_status[gi];
      assign led_out[gi] = on ? ~led_pol_ff[gi] : led_pol_ff[gi];
      assign led_oe[gi]  = strap_done_ff;
    end
  endgenerate

  // ------------------------------------------------------------
  // transmit jabber check
  // ------------------------------------------------------------
  reg [15:0] jab_cnt_ff;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      jab_cnt_ff   <= 16'h0000;
      tx_jabber_ff <= 1'b0;
    end else if (!jabber_check_en || !tx_en) begin
      jab_cnt_ff   <= 16'h0000;
      tx_jabber_ff <= 1'b0;
    end else if (jab_cnt_ff == JAB_CYC[15:0]) begin
      tx_jabber_ff <= 1'b1;
    end else begin
      jab_cnt_ff <= jab_cnt_ff + 16'h0001;
    end
  end

  // ------------------------------------------------------------
  // heartbeat after transmit; the stored inhibit never changes here
  // ------------------------------------------------------------
  reg        tx_en_d_ff;
  reg [15:0] hb_cnt_ff;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_en_d_ff       <= 1'b0;
      hb_cnt_ff        <= 16'h0000;
      col_heartbeat_ff <= 1'b0;
    end else begin
      tx_en_d_ff <= tx_en;
      if (tx_en_d_ff && !tx_en && hb_en) begin
        hb_cnt_ff        <= HB_CYC[15:0];
        col_heartbeat_ff <= 1'b1;
      end else if (hb_cnt_ff > 16'h0001) begin
        hb_cnt_ff <= hb_cnt_ff - 16'h0001;
      end else begin
        hb_cnt_ff        <= 16'h0000;
        col_heartbeat_ff <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // link integrity
  // ------------------------------------------------------------
  localparam LK_FAIL = 2'h0;
  localparam LK_DATA = 2'h1;
  localparam LK_PASS = 2'h2;
  reg [1:0] lk_ff;
  reg [1:0] nxt_lk;
  always @* begin
    nxt_lk = lk_ff;
    case (lk_ff)
      LK_FAIL: begin
        if (rx_valid_data)
          nxt_lk = ops_ff[`TBO_OPS_SQINH] ? LK_DATA : LK_PASS;
      end
      LK_DATA: begin
        if (rx_idle)
          nxt_lk = LK_PASS;
      end
      LK_PASS: begin
        if (!rx_link_pulse_ok)
          nxt_lk = LK_FAIL;
      end
      default: nxt_lk = LK_FAIL;
    endcase
    if (ops_ff[`TBO_OPS_LLINH])
      nxt_lk = LK_PASS;
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lk_ff        <= LK_FAIL;
      link_pass_ff <= 1'b0;
    end else begin
      lk_ff        <= nxt_lk;
      link_pass_ff <= (nxt_lk == LK_PASS);
    end
  end

endmodule

// ---- tbo_regs.vh ----
// register map, field positions and reset values for the 10base-t
// operations / extended control two register bank.
// assumes a 16-bit management data path in the low lanes of a 32-bit avalon word.
`ifndef TBO_REGS_VH
`define TBO_REGS_VH

// ------------------------------------------------------------
// register indices (byte address = index * 4)
// ------------------------------------------------------------
`define TBO_IDX_OPS        6'h12
`define TBO_IDX_EXT2       6'h13
`define TBO_IDX_STAT       6'h14
`define TBO_ADDR_W         8

// ------------------------------------------------------------
// operations register fields
// ------------------------------------------------------------
`define TBO_OPS_RJAB       15
`define TBO_OPS_POLREV     14
`define TBO_OPS_JABINH     5
`define TBO_OPS_RSV4       4
`define TBO_OPS_APINH      3
`define TBO_OPS_HBINH      2
`define TBO_OPS_LLINH      1
`define TBO_OPS_SQINH      0
`define TBO_OPS_WMASK      16'h3FFF
`define TBO_OPS_RST        16'h0010

// ------------------------------------------------------------
// extended control two fields
// ------------------------------------------------------------
`define TBO_EXT_NODREP     15
`define TBO_EXT_PRIO       14
`define TBO_EXT_RFLT       13
`define TBO_EXT_TXZ        7
`define TBO_EXT_FLED       5
`define TBO_EXT_APD        0
`define TBO_EXT_WMASK      16'h1BFF
`define TBO_EXT_RST        16'h0001

// ------------------------------------------------------------
// status register fields
// ------------------------------------------------------------
`define TBO_STAT_LINK      0
`define TBO_STAT_JAB       1
`define TBO_STAT_PWRDN     2
`define TBO_STAT_HBEN      3

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define TBO_CLK_NS         5
`define TBO_HB_NS          1000
`define TBO_STRAP_CYC      4'h4

`endif

// ---- tbo_ctrl_chk.sv ----
// checker: bus answers, heartbeat, jabber, pair and led gating
// assumes it is bound onto tbo_ctrl and sees only its ports
`include "tbo_regs.vh"
module tbo_chk #(
  parameter LED_N = 5
) (
  // clock, reset and bus
  input wire logic             clk,
  input wire logic             rst_b,
  input wire logic [7:0]       avs_address,
  input wire logic             avs_read,
  input wire logic             avs_write,
  input wire logic [31:0]      avs_readdata,
  input wire logic [1:0]       avs_response,
  // mode and status
  input wire logic             node_repeater_strap,
  input wire logic             tx_en,
  input wire logic             rx_active,
  input wire logic             full_duplex,
  input wire logic             mode_10m,
  input wire logic             pair_tx_positive,
  input wire logic             pair_tx_negative,
  input wire logic             pair_tx_oe,
  input wire logic             jabber_check_en,
  input wire logic             tx_jabber_ff,
  input wire logic             col_heartbeat_ff,
  input wire logic             crs,
  input wire logic             tx100_power_down,
  input wire logic [LED_N-1:0] led_oe
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  wire hit = avs_address[7:2] == `TBO_IDX_OPS || avs_address[7:2] == `TBO_IDX_EXT2 ||
             avs_address[7:2] == `TBO_IDX_STAT;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_unmapped_resp: assert property ((avs_read || avs_write) && !hit |=> avs_response == 2'h2)
    else $error("unmapped access not refused");
  a_unmapped_zero: assert property (avs_read && !hit |=> avs_readdata == 32'h0)
    else $error("unmapped read data not zero");
  a_mapped_ok: assert property (avs_read && hit |=> avs_response == 2'h0 && avs_readdata[31:16] == 16'h0)
    else $error("mapped read answered wrongly");
  a_pair_gate: assert property (pair_tx_positive || pair_tx_negative |-> pair_tx_oe)
    else $error("pair driven while floated");
  a_pwrdn_mode: assert property (tx100_power_down |-> mode_10m)
    else $error("power down outside 10 mode");
  a_hb_suppress: assert property ($rose(col_heartbeat_ff) |-> !$past(full_duplex) && !$past(node_repeater_strap))
    else $error("heartbeat in duplex or repeater");
  a_jab_cause: assert property ($rose(tx_jabber_ff) |-> $past(tx_en) && $past(jabber_check_en))
    else $error("jabber without enabled check");
  a_crs_repeater: assert property (node_repeater_strap && !rx_active |-> !crs)
    else $error("carrier sense without receive");
  a_led_wait: assert property ($rose(rst_b) |-> (led_oe == '0) [*4])
    else $error("leds driven before strap sampled");
  cover property ($rose(col_heartbeat_ff));
  cover property ($rose(tx_jabber_ff));
  cover property (avs_read && !hit);
endmodule

bind tbo_ctrl tbo_chk #(.LED_N(LED_N)) u_chk (.clk, .rst_b, .avs_address, .avs_read, .avs_write,
  .avs_readdata, .avs_response, .node_repeater_strap, .tx_en, .rx_active, .full_duplex, .mode_10m,
  .pair_tx_positive, .pair_tx_negative, .pair_tx_oe, .jabber_check_en, .tx_jabber_ff,
  .col_heartbeat_ff, .crs, .tx100_power_down, .led_oe);

// ---- tbo_sta.sv ----
// management entity model: avalon-mm master with read and write tasks
// assumes read data stands at the edge where waitrequest is low
module tbo_sta (
  // avalon-mm master
  input  wire logic        clk,
  output logic [7:0]       avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic [31:0]      avs_writedata,
  output logic [3:0]       avs_byteenable,
  input  wire logic [31:0] avs_readdata,
  input  wire logic [1:0]  avs_response,
  input  wire logic        avs_waitrequest
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {avs_address, avs_read, avs_write, avs_writedata, avs_byteenable} = {43'h0, 4'h3};
  // callers keep reserved bits at their defaults
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {16'h0, d};
    avs_write <= 1'b1;
    do @(posedge clk); while (avs_waitrequest);
    avs_write <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge clk); while (avs_waitrequest);
    d = avs_readdata;
    r = avs_response;
    avs_read <= 1'b0;
  endtask
endmodule

// ---- phy_tenbase_ops_ext_control_regs_test.sv ----
// self-checking bench for the operations / extended control register bank
// assumes tbo_ctrl, tbo_sta and tbo_chk are compiled first
`include "tbo_regs.vh"
module phy_tenbase_ops_ext_control_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam [7:0] AO = {`TBO_IDX_OPS, 2'h0};
  localparam [7:0] AE = {`TBO_IDX_EXT2, 2'h0};
  logic clk = 0, rst_b = 0, avs_read, avs_write, avs_waitrequest, hb, jb, cs;
  logic [7:0] avs_address;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, d;
  logic [1:0] avs_response, r;
  logic node_repeater_strap = 0, config_priority_strap = 1, rx_jabber_seen = 0, rx_pol_reversed = 0;
  logic rx_valid_data = 0, rx_idle = 0, rx_link_pulse_ok = 0, partner_remote_fault = 0;
  logic tx_en = 0, rx_active = 0, full_duplex = 0, mode_10m = 0;
  logic [4:0] led_strap = 5'h0A, led_status = 5'h00, led_out, led_oe;
  logic pair_tx_positive, pair_tx_negative, pair_tx_oe, polarity_correct_en, jabber_check_en;
  logic tx_jabber_ff, col_heartbeat_ff, crs, link_pass_ff, tx100_power_down;
  int fail_count = 0, n_compared = 0;
  always #2.5 clk = ~clk;
  // short counts keep the run brief
  tbo_ctrl #(.HB_CYC(4), .JAB_CYC(4)) dut (.clk, .rst_b, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response,
    .node_repeater_strap, .config_priority_strap, .led_strap, .rx_jabber_seen, .rx_pol_reversed,
    .rx_valid_data, .rx_idle, .rx_link_pulse_ok, .partner_remote_fault, .tx_en, .rx_active,
    .full_duplex, .mode_10m, .pair_tx_positive_in(1'b1), .pair_tx_negative_in(1'b1), .led_status,
    .pair_tx_positive, .pair_tx_negative, .pair_tx_oe, .polarity_correct_en, .jabber_check_en,
    .tx_jabber_ff, .col_heartbeat_ff, .crs, .link_pass_ff, .tx100_power_down, .led_out, .led_oe);
  tbo_sta sta (.clk, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_response, .avs_waitrequest);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task rdc(input string nm, input logic [7:0] a, input logic [15:0] e);
    sta.rd(a, d, r);
    chk(nm, d, {16'h0, e});
  endtask
  // transmit burst; heartbeat watched for 12 cycles after tx_en falls
  task txb(input int n);
    hb = 0;
    @(posedge clk) tx_en <= 1;
    repeat (n) @(posedge clk);
    #1 jb = tx_jabber_ff;
    cs = crs;
    @(posedge clk) tx_en <= 0;
    repeat (12) @(posedge clk) #1 hb = hb | col_heartbeat_ff;
  endtask
  task stop_test;
    if (fail_count == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #100000;
    fail_count++;
    stop_test;
  end
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1;
    repeat (4) @(posedge clk);
    rdc("ops_rst", AO, `TBO_OPS_RST);
    rdc("ext2_rst", AE, 16'h4001);
    rx_jabber_seen <= 1;
    rdc("rjab", AO, 16'h8010);
    rx_jabber_seen <= 0;
    rdc("rjab_set_wins", AO, 16'h8010);
    rdc("rjab_clr", AO, 16'h0010);
    chk("rjab_only", {tx_jabber_ff, col_heartbeat_ff, jabber_check_en}, 3'h1);
    rx_pol_reversed <= 1;
    rdc("pol_rev", AO, 16'h4010);
    chk("pol_run", {pair_tx_oe, polarity_correct_en}, 2'h3);
    rx_pol_reversed <= 0;
    rdc("pol_ok", AO, 16'h0010);
    sta.wr(AO, 16'hC03F);
    rdc("ops_rw", AO, 16'h003F);
    chk("jab_en", jabber_check_en, 0);
    chk("pol_en", polarity_correct_en, 0);
    chk("link", link_pass_ff, 1);
    txb(8);
    chk("jab_off", jb, 0);
    sta.wr(AO, 16'h0014);
    txb(8);
    chk("jab_on", jb, 1);
    chk("hb_inh", hb, 0);
    chk("crs_node", cs, 1);
    sta.wr(AO, 16'h0010);
    txb(2);
    chk("hb_node", hb, 1);
    chk("link_drop", link_pass_ff, 0);
    full_duplex <= 1;
    txb(2);
    chk("hb_fdx", hb, 0);
    full_duplex <= 0;
    node_repeater_strap <= 1;
    txb(2);
    chk("hb_rep", hb, 0);
    chk("crs_rep", cs, 0);
    rdc("ext2_rep", AE, 16'hC001);
    rdc("ops_kept", AO, 16'h0010);
    node_repeater_strap <= 0;
    partner_remote_fault <= 1;
    mode_10m <= 1;
    sta.wr(AE, 16'h00A1);
    rdc("ext2_rw", AE, 16'h60A1);
    chk("pair_z", {pair_tx_oe, pair_tx_positive, pair_tx_negative}, 0);
    chk("led_on", {led_oe, led_out}, {5'h1F, 5'h15});
    chk("pwrdn", tx100_power_down, 1);
    sta.wr(AE, 16'h0000);
    rx_valid_data <= 1;
    rx_idle <= 1;
    rx_link_pulse_ok <= 1;
    led_status <= 5'h1F;
    @(posedge clk);
    chk("pair_on", {pair_tx_oe, pair_tx_positive}, 2'h3);
    chk("pwr_on", tx100_power_down, 0);
    rdc("ext2_rf", AE, 16'h6000);
    chk("link_data", link_pass_ff, 1);
    sta.rd(8'h00, d, r);
    chk("unm_resp", r, 2'h2);
    chk("unm_data", d, 0);
    stop_test;
  end
endmodule
